// File: include/cfgfd_map.vh
`ifndef CFGFD_MAP_VH
`define CFGFD_MAP_VH

// ----------------------------------------------------------------
// configuration space addressing
// ----------------------------------------------------------------
`define CFGFD_ADDR_W 22
`define CFGFD_BASE_HI 18'h3_0000
`define CFGFD_ADDR_BOR 22'h30_0002
`define CFGFD_ADDR_WDT 22'h30_0003
`define CFGFD_ADDR_PIN 22'h30_0005
`define CFGFD_ADDR_CORE 22'h30_0006
`define CFGFD_ADDR_CP 22'h30_0008
`define CFGFD_ADDR_CPBE 22'h30_0009
`define CFGFD_ADDR_WP 22'h30_000A

// cell indices, low nibble of the byte address
`define CFGFD_IDX_BOR 4'h2
`define CFGFD_IDX_WDT 4'h3
`define CFGFD_IDX_PIN 4'h5
`define CFGFD_IDX_CORE 4'h6
`define CFGFD_IDX_CP 4'h8
`define CFGFD_IDX_CPBE 4'h9
`define CFGFD_IDX_WP 4'hA
`define CFGFD_IDX_FIRST 4'h2
`define CFGFD_IDX_LAST 4'hA

// ----------------------------------------------------------------
// implemented bit masks and unprogrammed values
// ----------------------------------------------------------------
`define CFGFD_MASK_BOR 8'h1F
`define CFGFD_MASK_WDT 8'h1F
`define CFGFD_MASK_PIN 8'h86
`define CFGFD_MASK_CORE 8'hF5
`define CFGFD_MASK_CP 8'h3F
`define CFGFD_MASK_CPBE 8'hC0
`define CFGFD_MASK_WP 8'h3F
`define CFGFD_DEF_BOR 8'h1F
`define CFGFD_DEF_WDT 8'h1F
`define CFGFD_DEF_PIN 8'h82
`define CFGFD_DEF_CORE 8'h85
`define CFGFD_DEF_CP 8'h3F
`define CFGFD_DEF_CPBE 8'hC0
`define CFGFD_DEF_WP 8'h3F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFGFD_BIT_POWERUP_TIMER 0
`define CFGFD_LSB_BORMODE 1
`define CFGFD_LSB_BORLEVEL 3
`define CFGFD_BIT_WDTON 0
`define CFGFD_LSB_WDTPS 1
`define CFGFD_BIT_RSTPIN 7
`define CFGFD_BIT_LPOSC 2
`define CFGFD_BIT_PBAD 1
`define CFGFD_BIT_DEBUG 7
`define CFGFD_BIT_XISA 6
`define CFGFD_BIT_BBHI 5
`define CFGFD_BIT_BBLO 4
`define CFGFD_BIT_SSP 2
`define CFGFD_BIT_STKRST 0
`define CFGFD_BIT_EEGUARD 7
`define CFGFD_BIT_BOOTGUARD 6

// ----------------------------------------------------------------
// mode codes, sizes and block boundaries
// ----------------------------------------------------------------
`define CFGFD_BOR_HW 2'h3
`define CFGFD_BOR_HW_AWAKE 2'h2
`define CFGFD_BOR_SW 2'h1
`define CFGFD_BOR_OFF 2'h0
`define CFGFD_BOOT_4K 13'h1000
`define CFGFD_BOOT_2K 13'h0800
`define CFGFD_BOOT_1K 13'h0400
`define CFGFD_BOOT_END 24'h00_07FF
`define CFGFD_BLOCK_LAST 3'h5

`endif

// File: hw/cfgfd_cell_store.v
`include "cfgfd_map.vh"

// nonvolatile configuration cells, one byte per index, registered read
module cfgfd_cell_store (
  // clock and erase
  input wire clock,
  input wire eraseRstn,
  // write port
  input wire writeEn,
  input wire clearOnly,
  input wire [3:0] writeIdx,
  input wire [7:0] writeData,
  // read port
  input wire readEn,
  input wire [3:0] readIdx,
  output reg [7:0] readData
);

  reg [7:0] cells [0:15];
  integer i;

  // ----------------------------------------------------------------
  // unprogrammed contents
  // ----------------------------------------------------------------
  function [7:0] blankValue;
    input [3:0] idx;
    begin
      case (idx)
        `CFGFD_IDX_BOR: blankValue = `CFGFD_DEF_BOR;
        `CFGFD_IDX_WDT: blankValue = `CFGFD_DEF_WDT;
        `CFGFD_IDX_PIN: blankValue = `CFGFD_DEF_PIN;
        `CFGFD_IDX_CORE: blankValue = `CFGFD_DEF_CORE;
        `CFGFD_IDX_CP: blankValue = `CFGFD_DEF_CP;
        `CFGFD_IDX_CPBE: blankValue = `CFGFD_DEF_CPBE;
        `CFGFD_IDX_WP: blankValue = `CFGFD_DEF_WP;
        default: blankValue = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // cell array
  // ----------------------------------------------------------------
  // erase restores every cell; a clear-only write can drop bits, never raise them
  always @(posedge clock or negedge eraseRstn) begin
    if (!eraseRstn) begin
      for (i = 0; i < 16; i = i + 1) begin
        cells[i] <= blankValue(i[3:0]);
      end
    end else if (writeEn) begin
      if (clearOnly) begin
        cells[writeIdx] <= cells[writeIdx] & writeData;
      end else begin
        cells[writeIdx] <= writeData;
      end
    end
  end

  // read data stand one cycle, zero otherwise
  always @(posedge clock or negedge eraseRstn) begin
    if (!eraseRstn) begin
      readData <= 8'h00;
    end else if (readEn) begin
      readData <= cells[readIdx];
    end else begin
      readData <= 8'h00;
    end
  end

endmodule

// File: hw/cfgfd_guard_check.v
`include "cfgfd_map.vh"

// maps a program memory address onto its protection block
module cfgfd_guard_check (
  // address under test
  input wire [23:0] progAddr,
  // active-high guards
  input wire [5:0] blockReadGuard,
  input wire bootReadGuard,
  input wire [5:0] blockWriteGuard,
  // verdicts
  output reg readBlocked,
  output reg writeBlocked
);

  wire [2:0] blockNum;
  wire inBoot;
  wire inBlocks;

  assign blockNum = progAddr[16:14];
  assign inBoot = (progAddr <= `CFGFD_BOOT_END);
  assign inBlocks = (progAddr[23:17] == 7'h00) && (blockNum <= `CFGFD_BLOCK_LAST);

  // boot block sits below block 0; blocks are 16 KB above it
  always @* begin
    readBlocked = 1'b0;
    writeBlocked = 1'b0;
    if (inBoot) begin
      readBlocked = bootReadGuard;
    end else if (inBlocks) begin
      readBlocked = blockReadGuard[blockNum];
      writeBlocked = blockWriteGuard[blockNum];
    end
  end

endmodule

// File: hw/cfgfd_decoder.v
`include "cfgfd_map.vh"

// Overview of operation
// - brown-out mode 11 hardware only, 01 software bit, 00 off
// - brown-out mode 10 hardware only, suspended during sleep, software bit ignored
// - trip level from bits 4-3, 11 minimum, 00 maximum
// - power-up timer enable is active low in bit 0
// - power-up timer decoded independently of every brown-out field
// - watchdog postscale bits 4-1 give a divide by two to the field
// - watchdog bit 0 set forces watchdog on, clear defers to software enable
// - reset-pin bit 7 picks external reset or general input
// - bit 2 picks low-power or higher-power secondary timer oscillator
// - bit 1 sets port B analog or digital reset default
// - debug bit 7 active low, dedicates the two debug pins
// - bit 6 enables extended instruction set and indexed addressing
// - boot size 11 or 10 gives 4K, 01 2K, 00 1K words
// - bit 2 enables single-supply programming
// - bit 0 lets stack full or underflow reset the device
// - six read guards protect program blocks 0 to 5, active low
// - bit 7 guards data EEPROM, bit 6 guards addresses 0 to 7FFh whatever the boot size, active low
// - six write guards block writes to the same blocks, active low
// - unimplemented bits read back as zero
// - guard bits start at one, read back, and can only clear
// - cells read 0 programmed, 1 unprogrammed, from byte address 300000h
module cfgfd_decoder (
  // clock and resets
  input wire clock,
  input wire rstn,
  input wire powerOnRstn,
  // register port
  input wire [21:0] regAddr,
  input wire [7:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  output wire [7:0] regReadData,
  // run-time inputs from the core
  input wire sleepMode,
  input wire swBrownoutEnable,
  input wire swWatchdogEnable,
  input wire [23:0] progAddr,
  // brown-out and power-up
  output reg brownoutResetActive,
  output reg [1:0] brownoutLevelSel,
  output reg swBrownoutHonoured,
  output reg powerupTimerEnable,
  // watchdog
  output reg [3:0] watchdogPostscaleSel,
  output reg [15:0] watchdogDivRatio,
  output reg watchdogRunning,
  // pins and oscillator
  output reg resetPinSelect,
  output reg altInputPinEnable,
  output reg lowPowerTmrOsc,
  output reg portbAnalogDefault,
  // core and debug
  output reg debuggerEnable,
  output reg extendedIsaEn,
  output reg [12:0] bootBlockWords,
  output reg singleSupplyProgEn,
  output reg stackFaultResetEn,
  // protection
  output reg [5:0] blockReadGuard,
  output reg eepromReadGuard,
  output reg bootReadGuard,
  output reg [5:0] blockWriteGuard,
  output reg progReadBlocked,
  output reg progWriteBlocked
);

  // ----------------------------------------------------------------
  // reset synchronisers
  // ----------------------------------------------------------------
  reg rstMeta;
  reg rstSync;
  reg porMeta;
  reg porSync;

  // device reset released through two flops
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // power-on reset released through two flops
  always @(posedge clock or negedge powerOnRstn) begin
    if (!powerOnRstn) begin
      porMeta <= 1'b0;
      porSync <= 1'b0;
    end else begin
      porMeta <= 1'b1;
      porSync <= porMeta;
    end
  end

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  function cellMapped;
    input [21:0] addr;
    begin
      cellMapped = 1'b0;
      if (addr[21:4] == `CFGFD_BASE_HI) begin
        case (addr[3:0])
          `CFGFD_IDX_BOR, `CFGFD_IDX_WDT, `CFGFD_IDX_PIN, `CFGFD_IDX_CORE,
          `CFGFD_IDX_CP, `CFGFD_IDX_CPBE, `CFGFD_IDX_WP: cellMapped = 1'b1;
          default: cellMapped = 1'b0;
        endcase
      end
    end
  endfunction

  function [7:0] implMask;
    input [3:0] idx;
    begin
      case (idx)
        `CFGFD_IDX_BOR: implMask = `CFGFD_MASK_BOR;
        `CFGFD_IDX_WDT: implMask = `CFGFD_MASK_WDT;
        `CFGFD_IDX_PIN: implMask = `CFGFD_MASK_PIN;
        `CFGFD_IDX_CORE: implMask = `CFGFD_MASK_CORE;
        `CFGFD_IDX_CP: implMask = `CFGFD_MASK_CP;
        `CFGFD_IDX_CPBE: implMask = `CFGFD_MASK_CPBE;
        `CFGFD_IDX_WP: implMask = `CFGFD_MASK_WP;
        default: implMask = 8'h00;
      endcase
    end
  endfunction

  function isGuardCell;
    input [3:0] idx;
    begin
      isGuardCell = (idx == `CFGFD_IDX_CP) || (idx == `CFGFD_IDX_CPBE) ||
                    (idx == `CFGFD_IDX_WP);
    end
  endfunction

  // ----------------------------------------------------------------
  // cell store access
  // ----------------------------------------------------------------
  reg [3:0] scanIdx;
  reg [3:0] scanIdxD;
  reg scanValidD;
  wire inDeviceReset;
  wire busHit;
  wire storeWrite;
  wire storeRead;
  wire [3:0] storeReadIdx;
  wire [7:0] storeWriteData;
  wire [7:0] cellData;

  assign inDeviceReset = ~rstSync;
  assign busHit = cellMapped(regAddr);
  // bus is served only outside device reset; scan owns the read port then
  assign storeWrite = regWrite & busHit & rstSync;
  assign storeRead = inDeviceReset | (regRead & busHit);
  assign storeReadIdx = inDeviceReset ? scanIdx : regAddr[3:0];
  // unimplemented bits are stored as zero so they read back as zero
  assign storeWriteData = regWriteData & implMask(regAddr[3:0]);
  // unmapped reads answer zero because the store clears its output
  assign regReadData = cellData;

  cfgfd_cell_store cellStore (
    .clock(clock),
    .eraseRstn(porSync),
    .writeEn(storeWrite),
    .clearOnly(isGuardCell(regAddr[3:0])),
    .writeIdx(regAddr[3:0]),
    .writeData(storeWriteData),
    .readEn(storeRead),
    .readIdx(storeReadIdx),
    .readData(cellData)
  );

  // ----------------------------------------------------------------
  // reset-time scan of the cells
  // ----------------------------------------------------------------
  // walk indices 2h to Ah, unmapped 4h and 7h included, repeatedly while the device is held in reset
  always @(posedge clock or negedge porSync) begin
    if (!porSync) begin
      scanIdx <= `CFGFD_IDX_FIRST;
      scanIdxD <= `CFGFD_IDX_FIRST;
      scanValidD <= 1'b0;
    end else begin
      scanIdxD <= scanIdx;
      scanValidD <= inDeviceReset;
      if (!inDeviceReset || scanIdx == `CFGFD_IDX_LAST) begin
        scanIdx <= `CFGFD_IDX_FIRST;
      end else begin
        scanIdx <= scanIdx + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // shadow copies of the cells
  // ----------------------------------------------------------------
  reg [7:0] borCfg;
  reg [7:0] wdtCfg;
  reg [7:0] pinCfg;
  reg [7:0] coreCfg;
  reg [7:0] cpCfg;
  reg [7:0] cpbeCfg;
  reg [7:0] wpCfg;

  // shadows change only while the device is in reset
  always @(posedge clock or negedge porSync) begin
    if (!porSync) begin
      borCfg <= `CFGFD_DEF_BOR;
      wdtCfg <= `CFGFD_DEF_WDT;
      pinCfg <= `CFGFD_DEF_PIN;
      coreCfg <= `CFGFD_DEF_CORE;
      cpCfg <= `CFGFD_DEF_CP;
      cpbeCfg <= `CFGFD_DEF_CPBE;
      wpCfg <= `CFGFD_DEF_WP;
    end else if (scanValidD && inDeviceReset) begin
      case (scanIdxD)
        `CFGFD_IDX_BOR: borCfg <= cellData;
        `CFGFD_IDX_WDT: wdtCfg <= cellData;
        `CFGFD_IDX_PIN: pinCfg <= cellData;
        `CFGFD_IDX_CORE: coreCfg <= cellData;
        `CFGFD_IDX_CP: cpCfg <= cellData;
        `CFGFD_IDX_CPBE: cpbeCfg <= cellData;
        `CFGFD_IDX_WP: wpCfg <= cellData;
        default: borCfg <= borCfg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire [1:0] brownoutModeSel;
  wire [3:0] postscaleField;
  wire [1:0] bootSizeField;
  wire progReadHit;
  wire progWriteHit;
  reg next_brownoutResetActive;
  reg [12:0] next_bootBlockWords;

  assign brownoutModeSel = borCfg[`CFGFD_LSB_BORMODE +: 2];
  assign postscaleField = wdtCfg[`CFGFD_LSB_WDTPS +: 4];
  assign bootSizeField = {coreCfg[`CFGFD_BIT_BBHI], coreCfg[`CFGFD_BIT_BBLO]};

  // brown-out reset request from the mode field
  always @* begin
    case (brownoutModeSel)
      `CFGFD_BOR_HW: next_brownoutResetActive = 1'b1;
      `CFGFD_BOR_HW_AWAKE: next_brownoutResetActive = ~sleepMode;
      `CFGFD_BOR_SW: next_brownoutResetActive = swBrownoutEnable;
      `CFGFD_BOR_OFF: next_brownoutResetActive = 1'b0;
      default: next_brownoutResetActive = 1'b0;
    endcase
  end

  // boot block size in words
  always @* begin
    case (bootSizeField)
      2'h3, 2'h2: next_bootBlockWords = `CFGFD_BOOT_4K;
      2'h1: next_bootBlockWords = `CFGFD_BOOT_2K;
      2'h0: next_bootBlockWords = `CFGFD_BOOT_1K;
      default: next_bootBlockWords = `CFGFD_BOOT_1K;
    endcase
  end

  cfgfd_guard_check guardCheck (
    .progAddr(progAddr),
    .blockReadGuard(~cpCfg[5:0]),
    .bootReadGuard(~cpbeCfg[`CFGFD_BIT_BOOTGUARD]),
    .blockWriteGuard(~wpCfg[5:0]),
    .readBlocked(progReadHit),
    .writeBlocked(progWriteHit)
  );

  // ----------------------------------------------------------------
  // registered settings
  // ----------------------------------------------------------------
  // every setting is a flop fed from the shadows or run-time inputs; cleared until power-on release, except watchdogDivRatio at 1 and bootBlockWords at 1K
  always @(posedge clock or negedge porSync) begin
    if (!porSync) begin
      brownoutResetActive <= 1'b0;
      brownoutLevelSel <= 2'h0;
      swBrownoutHonoured <= 1'b0;
      powerupTimerEnable <= 1'b0;
      watchdogPostscaleSel <= 4'h0;
      watchdogDivRatio <= 16'h0001;
      watchdogRunning <= 1'b0;
      resetPinSelect <= 1'b0;
      altInputPinEnable <= 1'b0;
      lowPowerTmrOsc <= 1'b0;
      portbAnalogDefault <= 1'b0;
      debuggerEnable <= 1'b0;
      extendedIsaEn <= 1'b0;
      bootBlockWords <= `CFGFD_BOOT_1K;
      singleSupplyProgEn <= 1'b0;
      stackFaultResetEn <= 1'b0;
      blockReadGuard <= 6'h00;
      eepromReadGuard <= 1'b0;
      bootReadGuard <= 1'b0;
      blockWriteGuard <= 6'h00;
      progReadBlocked <= 1'b0;
      progWriteBlocked <= 1'b0;
    end else begin
      brownoutResetActive <= next_brownoutResetActive;
      brownoutLevelSel <= borCfg[`CFGFD_LSB_BORLEVEL +: 2];
      swBrownoutHonoured <= (brownoutModeSel == `CFGFD_BOR_SW);
      powerupTimerEnable <= ~borCfg[`CFGFD_BIT_POWERUP_TIMER];
      watchdogPostscaleSel <= postscaleField;
      watchdogDivRatio <= 16'h0001 << postscaleField;
      watchdogRunning <= wdtCfg[`CFGFD_BIT_WDTON] | swWatchdogEnable;
      resetPinSelect <= pinCfg[`CFGFD_BIT_RSTPIN];
      altInputPinEnable <= ~pinCfg[`CFGFD_BIT_RSTPIN];
      lowPowerTmrOsc <= pinCfg[`CFGFD_BIT_LPOSC];
      portbAnalogDefault <= pinCfg[`CFGFD_BIT_PBAD];
      debuggerEnable <= ~coreCfg[`CFGFD_BIT_DEBUG];
      extendedIsaEn <= coreCfg[`CFGFD_BIT_XISA];
      bootBlockWords <= next_bootBlockWords;
      singleSupplyProgEn <= coreCfg[`CFGFD_BIT_SSP];
      stackFaultResetEn <= coreCfg[`CFGFD_BIT_STKRST];
      blockReadGuard <= ~cpCfg[5:0];
      eepromReadGuard <= ~cpbeCfg[`CFGFD_BIT_EEGUARD];
      bootReadGuard <= ~cpbeCfg[`CFGFD_BIT_BOOTGUARD];
      blockWriteGuard <= ~wpCfg[5:0];
      progReadBlocked <= progReadHit;
      progWriteBlocked <= progWriteHit;
    end
  end

endmodule

// File: tb/cfgfd_decoder_props.sv
`include "cfgfd_map.vh"

// watches the register port and the decoded settings of the decoder
module cfgfd_decoder_props (
  // clock and resets
  input wire clock,
  input wire rstn,
  input wire powerOnRstn,
  // register port
  input wire [21:0] regAddr,
  input wire regRead,
  input wire [7:0] regReadData,
  // run-time inputs and settings
  input wire swBrownoutEnable,
  input wire swWatchdogEnable,
  input wire brownoutResetActive,
  input wire swBrownoutHonoured,
  input wire [3:0] watchdogPostscaleSel,
  input wire [15:0] watchdogDivRatio,
  input wire watchdogRunning,
  input wire resetPinSelect,
  input wire altInputPinEnable,
  input wire [12:0] bootBlockWords,
  input wire [5:0] blockReadGuard
);
  reg [2:0] settle;
  wire ok;

  // cycles since both resets let go, saturating, so the scan never counts
  always @(posedge clock or negedge rstn or negedge powerOnRstn) begin
    if (!rstn || !powerOnRstn) begin
      settle <= 3'h0;
    end else if (settle != 3'h7) begin
      settle <= settle + 3'h1;
    end
  end
  assign ok = (settle == 3'h7);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn || !powerOnRstn);

  // a read strobe to one address once settled
  sequence rdAt(a);
    ok && regRead && regAddr == a;
  endsequence

  a_unmapped_zero: assert property (rdAt(22'h30_0004) |=> regReadData == 8'h00)
    else $error("unmapped read not zero");
  a_bor_spare_zero: assert property (rdAt(`CFGFD_ADDR_BOR) |=> regReadData[7:5] == 3'h0)
    else $error("brownout byte spare bits set");
  a_core_spare_zero: assert property (rdAt(`CFGFD_ADDR_CORE) |=> !regReadData[3] && !regReadData[1])
    else $error("core byte spare bits set");
  a_guard_spare_zero: assert property (rdAt(`CFGFD_ADDR_CP) |=> regReadData[7:6] == 2'h0)
    else $error("guard byte spare bits set");
  a_wdt_ratio_pow: assert property (ok |-> watchdogDivRatio == (16'h0001 << watchdogPostscaleSel))
    else $error("watchdog ratio wrong");
  a_pin_use_excl: assert property (ok |-> altInputPinEnable != resetPinSelect)
    else $error("reset pin use not exclusive");
  a_boot_size_legal: assert property (ok |-> bootBlockWords inside {13'h1000, 13'h0800, 13'h0400})
    else $error("boot size illegal");
  a_wdt_sw_on: assert property (ok && swWatchdogEnable |=> watchdogRunning)
    else $error("software watchdog enable ignored");
  a_bor_sw_follow: assert property (ok && swBrownoutHonoured |-> brownoutResetActive == $past(swBrownoutEnable))
    else $error("software brownout not followed");
  a_settings_hold: assert property (ok && $past(ok) |-> $stable(bootBlockWords) && $stable(blockReadGuard))
    else $error("settings moved outside reset");
endmodule

bind cfgfd_decoder cfgfd_decoder_props i_props (.clock(clock), .rstn(rstn),
  .powerOnRstn(powerOnRstn), .regAddr(regAddr), .regRead(regRead), .regReadData(regReadData),
  .swBrownoutEnable(swBrownoutEnable), .swWatchdogEnable(swWatchdogEnable),
  .brownoutResetActive(brownoutResetActive), .swBrownoutHonoured(swBrownoutHonoured),
  .watchdogPostscaleSel(watchdogPostscaleSel), .watchdogDivRatio(watchdogDivRatio),
  .watchdogRunning(watchdogRunning), .resetPinSelect(resetPinSelect),
  .altInputPinEnable(altInputPinEnable), .bootBlockWords(bootBlockWords),
  .blockReadGuard(blockReadGuard));

// File: tb/config_fuse_decoder_test.sv
`include "cfgfd_map.vh"

module config_fuse_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, powerOnRstn, regWrite, regRead, sleepMode;
  logic swBrownoutEnable, swWatchdogEnable;
  logic [21:0] regAddr;
  logic [7:0] regWriteData, regReadData;
  logic [23:0] progAddr;
  logic borAct, eepG, bootG, rdBlk, wrBlk;
  logic [1:0] borLvl;
  logic swBorH, powerup_timer_en_n, wdtRun, rstPin, altIn, lpOsc, pbAna, dbgEn, xIsa, sspEn, stkEn;
  logic [3:0] wdtPs, f, prevPs;
  logic [15:0] wdtDiv;
  logic [12:0] bootW;
  logic [5:0] rdG, wrG;
  logic [7:0] dflt [16];
  logic [23:0] addrs [11];
  logic [2:0] b;
  logic e;
  int nErrors, cmpCount, i, s;

  cfgfd_decoder i_dut (.clock, .rstn, .powerOnRstn, .regAddr, .regWriteData, .regWrite,
    .regRead, .regReadData, .sleepMode, .swBrownoutEnable, .swWatchdogEnable, .progAddr,
    .brownoutResetActive(borAct), .brownoutLevelSel(borLvl), .swBrownoutHonoured(swBorH),
    .powerupTimerEnable(powerup_timer_en_n), .watchdogPostscaleSel(wdtPs), .watchdogDivRatio(wdtDiv),
    .watchdogRunning(wdtRun), .resetPinSelect(rstPin), .altInputPinEnable(altIn),
    .lowPowerTmrOsc(lpOsc), .portbAnalogDefault(pbAna), .debuggerEnable(dbgEn),
    .extendedIsaEn(xIsa), .bootBlockWords(bootW), .singleSupplyProgEn(sspEn),
    .stackFaultResetEn(stkEn), .blockReadGuard(rdG), .eepromReadGuard(eepG),
    .bootReadGuard(bootG), .blockWriteGuard(wrG), .progReadBlocked(rdBlk),
    .progWriteBlocked(wrBlk));

  // free-running clock, 10 ns period
  always #5 clock = ~clock;

  task automatic endSim;
    if (nErrors == 0 && cmpCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic ck(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'h1;
    @(posedge clock);
    regWrite <= 1'h0;
  endtask

  // one-cycle read strobe, data looked at in the following cycle
  task automatic rd(input logic [21:0] a, input logic [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clock);
    regRead <= 1'h0;
    #1 ck("regReadData", 16'(regReadData), 16'(exp));
  endtask

  // device reset long enough for a full scan of the cells
  task automatic devReset;
    @(posedge clock);
    rstn <= 1'h0;
    repeat (14) @(posedge clock);
    rstn <= 1'h1;
    repeat (4) @(posedge clock);
    #1;
  endtask

  // hang guard
  initial begin
    #200us;
    nErrors++;
    endSim;
  end

  initial begin
    {clock, rstn, powerOnRstn, regWrite, regRead, sleepMode} = 6'h00;
    {swBrownoutEnable, swWatchdogEnable, regAddr, regWriteData, progAddr} = 56'h0;
    dflt = '{0, 0, 8'h1F, 8'h1F, 0, 8'h82, 8'h85, 0, 8'h3F, 8'hC0, 8'h3F, 0, 0, 0, 0, 0};
    addrs = '{0, 24'h7FF, 24'h800, 24'h3FFF, 24'h4000, 24'hBFFF, 24'hC000, 24'h1_0000,
      24'h1_4000, 24'h1_7FFF, 24'h1_8000};
    repeat (3) @(posedge clock);
    powerOnRstn <= 1'h1;
    devReset;
    // erased cells, unmapped holes and spare bits
    for (i = 0; i < 16; i++) rd(22'h30_0000 | 22'(i), dflt[i]);
    // writes during device reset are dropped
    @(posedge clock);
    rstn <= 1'h0;
    wr(`CFGFD_ADDR_CP, 8'h00);
    devReset;
    rd(`CFGFD_ADDR_CP, 8'h3F);
    prevPs = 4'hF;
    // every field value, settings move only through a device reset
    for (i = 0; i < 16; i++) begin
      f = 4'(i);
      wr(`CFGFD_ADDR_BOR, {3'h7, f[1:0], f[3:2], f[0]});
      wr(`CFGFD_ADDR_WDT, {3'h7, f, f[1]});
      wr(`CFGFD_ADDR_PIN, {f[0], 4'hF, f[1], f[2], 1'h1});
      wr(`CFGFD_ADDR_CORE, {f[0], f[1], f[3:2], 1'h1, f[2], 1'h1, f[3]});
      rd(`CFGFD_ADDR_BOR, {3'h0, f[1:0], f[3:2], f[0]});
      rd(`CFGFD_ADDR_PIN, {f[0], 4'h0, f[1], f[2], 1'h0});
      rd(`CFGFD_ADDR_CORE, {f[0], f[1], f[3:2], 1'h0, f[2], 1'h0, f[3]});
      ck("wdtPs", 16'(wdtPs), 16'(prevPs));
      devReset;
      prevPs = f;
      ck("borLvl", 16'(borLvl), 16'(f[1:0]));
      ck("powerup_timer_en_n", 16'(powerup_timer_en_n), 16'(!f[0]));
      ck("swBorH", 16'(swBorH), 16'(f[3:2] == 2'h1));
      ck("wdtPs", 16'(wdtPs), 16'(f));
      ck("wdtDiv", wdtDiv, 16'h0001 << f);
      ck("rstPin", 16'({rstPin, altIn}), 16'({f[0], ~f[0]}));
      ck("lpOsc", 16'(lpOsc), 16'(f[1]));
      ck("pbAna", 16'(pbAna), 16'(f[2]));
      ck("dbgEn", 16'(dbgEn), 16'(!f[0]));
      ck("xIsa", 16'(xIsa), 16'(f[1]));
      ck("bootW", 16'(bootW), f[3] ? 16'h1000 : (f[2] ? 16'h0800 : 16'h0400));
      ck("sspEn", 16'(sspEn), 16'(f[2]));
      ck("stkEn", 16'(stkEn), 16'(f[3]));
      for (s = 0; s < 4; s++) begin
        @(posedge clock);
        sleepMode <= s[0];
        swBrownoutEnable <= s[1];
        swWatchdogEnable <= s[1];
        repeat (2) @(posedge clock);
        #1;
        e = (f[3:2] == 2'h3) | (f[3:2] == 2'h2 & !s[0]) | (f[3:2] == 2'h1 & s[1]);
        ck("borAct", 16'(borAct), 16'(e));
        ck("wdtRun", 16'(wdtRun), 16'(f[1] | s[1]));
      end
    end
    // guard cells only clear
    wr(`CFGFD_ADDR_CP, 8'h2A);
    wr(`CFGFD_ADDR_CP, 8'hFF);
    rd(`CFGFD_ADDR_CP, 8'h2A);
    wr(`CFGFD_ADDR_CPBE, 8'hBF);
    rd(`CFGFD_ADDR_CPBE, 8'h80);
    wr(`CFGFD_ADDR_WP, 8'h15);
    rd(`CFGFD_ADDR_WP, 8'h15);
    devReset;
    ck("rdG", 16'(rdG), 16'h0015);
    ck("eepBoot", 16'({eepG, bootG}), 16'h0001);
    ck("wrG", 16'(wrG), 16'h002A);
    // block boundaries of the protected program space
    for (i = 0; i < 11; i++) begin
      @(posedge clock);
      progAddr <= addrs[i];
      repeat (2) @(posedge clock);
      #1;
      b = (addrs[i] < 24'h800) ? 3'h6 : (addrs[i] < 24'h4000) ? 3'h0 : 3'(addrs[i] >> 14);
      b = (addrs[i] > 24'h1_7FFF) ? 3'h7 : b;
      ck("rdBlk", 16'(rdBlk), 16'(b == 3'h6 ? 1'h1 : (b < 3'h6 ? 6'h15 >> b : 6'h0)) & 16'h0001);
      ck("wrBlk", 16'(wrBlk), 16'(b < 3'h6 ? 6'h2A >> b : 6'h0) & 16'h0001);
    end
    endSim;
  end
endmodule
